// >>> src/sram_port_pkg.sv
/*
  constants and carrier types for the separate-io burst-of-two sram port model.
  assumes a single system clock at 125 mhz that oversamples the link clocks.
*/
package sram_port_pkg;
  // ==========================================================
  // organisation
  localparam int unsigned LANE_BITS = 9;
  localparam int unsigned LANES = 4;
  localparam int unsigned DATA_BITS = LANE_BITS * LANES;
  localparam int unsigned ADDR_BITS = 10;
  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned STOP_TIME_NS = 30;
  localparam int unsigned STOP_CYCLES = (STOP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned LOCK_PERIOD_CYCLES = 2048;
  localparam int unsigned CAL_CYCLES = 1024;
  localparam int unsigned CAL_INTERVAL = 1024;
  localparam logic [3:0] CAL_MID = 4'h8;
  localparam int unsigned FIFO_DEPTH = 8;

  typedef struct packed {
    logic [DATA_BITS-1:0] data;
    logic [LANES-1:0] byte_write_mask_n;
  } beat_t;

  typedef struct packed {
    logic [ADDR_BITS-1:0] addr;
    beat_t b0;
    beat_t b1;
  } wr_req_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_BEAT0 = 2'b01,
    RD_BEAT1 = 2'b10
  } rd_state_t;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_ADDR = 2'b01,
    WR_DATA1 = 2'b10
  } wr_state_t;
endpackage

// >>> src/sram_port.sv
/*
  device-side logic of a separate-io burst-of-two ddr sram: command capture,
  buffered early writes with coherency, read pipeline, echo clocks, dll lock.
  assumes the link clocks k, k_n, c, c_n are much slower than clk and are
  sampled by clk; the controller keeps its own timing.
*/
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// fifo
module beat_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic push, pop;

  always_comb begin
    in_ready = (wp_q - rp_q) != (AW+1)'(DEPTH);
    out_valid = wp_q != rp_q;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    out_data = mem_q[rp_q[AW-1:0]];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end
endmodule

// ==========================================================
// device
module sram_port #(
  parameter int unsigned LOCK_CYCLES = sram_port_pkg::LOCK_PERIOD_CYCLES,
  parameter int unsigned STOP_CYCLES = sram_port_pkg::STOP_CYCLES,
  parameter int unsigned LANES = sram_port_pkg::LANES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic k,
  input wire logic k_n,
  input wire logic c,
  input wire logic c_n,
  input wire logic dll_enable,
  input wire logic read_sel_n,
  input wire logic write_sel_n,
  input wire logic [sram_port_pkg::ADDR_BITS-1:0] addr,
  input wire logic [sram_port_pkg::DATA_BITS-1:0] data_in,
  input wire logic [sram_port_pkg::LANES-1:0] byte_write_mask_n,
  output logic [sram_port_pkg::DATA_BITS-1:0] data_out,
  output logic data_out_oe,
  output logic echo_clock_true,
  output logic echo_clock_comp,
  output logic ready,
  output logic [3:0] drive_strength,
  output logic fifo_full
);
  localparam int unsigned AB = sram_port_pkg::ADDR_BITS;
  localparam int unsigned DB = sram_port_pkg::DATA_BITS;
  localparam int unsigned LB = sram_port_pkg::LANE_BITS;
  localparam int unsigned WRW = $bits(sram_port_pkg::wr_req_t);

  // ==========================================================
  // input synchronisers
  logic [9:0] s1_q, s2_q, s3_q;
  logic [AB-1:0] a1_q, a2_q;
  logic [DB-1:0] d1_q, d2_q;
  logic [sram_port_pkg::LANES-1:0] m1_q, m2_q;
  always_ff @(posedge clk) begin
    s1_q <= {k, k_n, c, c_n, dll_enable, read_sel_n, write_sel_n, 3'h0};
    s2_q <= s1_q;
    s3_q <= s2_q;
    a1_q <= addr;
    a2_q <= a1_q;
    d1_q <= data_in;
    d2_q <= d1_q;
    m1_q <= byte_write_mask_n;
    m2_q <= m1_q;
  end
  logic k_s, kn_s, c_s, cn_s, en_s, rsel_s, wsel_s;
  logic k_rise, kn_rise, c_rise, cn_rise, en_rise, single_clk;
  always_comb begin
    {k_s, kn_s, c_s, cn_s, en_s, rsel_s, wsel_s} = s2_q[9:3];
    k_rise = k_s && !s3_q[9];
    kn_rise = kn_s && !s3_q[8];
    c_rise = c_s && !s3_q[7];
    cn_rise = cn_s && !s3_q[6];
    en_rise = en_s && !s3_q[5];
    single_clk = c_s && cn_s;
  end

  // ==========================================================
  // dll lock, calibration
  logic [15:0] lock_q, lock_d, stop_q, stop_d;
  logic [11:0] cal_q, cal_d;
  logic [3:0] drv_q, drv_d;
  logic ready_q, ready_d;
  always_comb begin
    stop_d = (k_rise || kn_rise) ? 16'h0000 : stop_q + 16'h0001;
    lock_d = lock_q;
    ready_d = ready_q;
    if (en_rise || stop_q == 16'(STOP_CYCLES)) begin
      lock_d = 16'h0000;
      ready_d = 1'b0;
    end else if (!en_s) begin
      ready_d = lock_q >= 16'(LOCK_CYCLES);
      if (k_rise && !ready_d) lock_d = lock_q + 16'h0001;
    end else if (k_rise && lock_q < 16'(LOCK_CYCLES)) begin
      lock_d = lock_q + 16'h0001;
    end else if (lock_q >= 16'(LOCK_CYCLES)) begin
      ready_d = 1'b1;
    end
    cal_d = (cal_q == 12'(sram_port_pkg::CAL_INTERVAL - 1)) ? 12'h000 : cal_q + 12'h001;
    drv_d = drv_q;
    if (cal_q == 12'(sram_port_pkg::CAL_CYCLES - 1)) drv_d = 4'hA;
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      lock_q <= 16'h0000;
      stop_q <= 16'h0000;
      ready_q <= 1'b0;
      cal_q <= 12'h000;
      drv_q <= sram_port_pkg::CAL_MID;
    end else begin
      lock_q <= lock_d;
      stop_q <= stop_d;
      ready_q <= ready_d;
      cal_q <= cal_d;
      drv_q <= drv_d;
    end
  end

  // ==========================================================
  // write machine and fifo of captured bursts
  sram_port_pkg::wr_state_t ws_q, ws_d;
  sram_port_pkg::wr_req_t wr_q, wr_d;
  logic push_q, push_d;
  logic fifo_in_ready, fifo_valid, fifo_pop;
  sram_port_pkg::wr_req_t fifo_out;
  always_comb begin
    ws_d = ws_q;
    wr_d = wr_q;
    push_d = 1'b0;
    unique case (ws_q)
      sram_port_pkg::WR_IDLE: begin
        if (k_rise && !wsel_s && fifo_in_ready) begin
          wr_d.b0 = '{data: d2_q, byte_write_mask_n: m2_q};
          ws_d = sram_port_pkg::WR_ADDR;
        end
      end
      sram_port_pkg::WR_ADDR: begin
        if (kn_rise) begin
          wr_d.addr = a2_q;
          wr_d.b1 = '{data: d2_q, byte_write_mask_n: m2_q};
          ws_d = sram_port_pkg::WR_DATA1;
        end
      end
      sram_port_pkg::WR_DATA1: begin
        push_d = 1'b1;
        ws_d = sram_port_pkg::WR_IDLE;
      end
      default: ws_d = sram_port_pkg::WR_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      ws_q <= sram_port_pkg::WR_IDLE;
      wr_q <= '0;
      push_q <= 1'b0;
    end else begin
      ws_q <= ws_d;
      wr_q <= wr_d;
      push_q <= push_d;
    end
  end
  beat_fifo #(.WIDTH(WRW), .DEPTH(sram_port_pkg::FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .in_data(wr_q),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  // ==========================================================
  // write buffers: three-deep, oldest commits on each new write once all three are valid
  sram_port_pkg::wr_req_t buf_q [3];
  sram_port_pkg::wr_req_t buf_d [3];
  logic [2:0] bv_q, bv_d;
  logic [DB-1:0] mem_q [2**AB];
  logic commit;
  always_comb begin
    fifo_pop = fifo_valid;
    commit = fifo_pop && bv_q[2];
    buf_d = buf_q;
    bv_d = bv_q;
    if (fifo_pop) begin
      buf_d[2] = buf_q[1];
      buf_d[1] = buf_q[0];
      buf_d[0] = fifo_out;
      bv_d = {bv_q[1:0], 1'b1};
    end
  end
  function automatic logic [DB-1:0] merge(input logic [DB-1:0] old,
                                          input sram_port_pkg::beat_t b);
    logic [DB-1:0] r;
    r = old;
    for (int i = 0; i < LANES; i++) begin
      if (!b.byte_write_mask_n[i]) r[i*LB +: LB] = b.data[i*LB +: LB];
    end
    return r;
  endfunction
  always_ff @(posedge clk) begin
    if (reset) begin
      bv_q <= 3'h0;
      for (int i = 0; i < 3; i++) buf_q[i] <= '0;
    end else begin
      bv_q <= bv_d;
      buf_q <= buf_d;
    end
    if (commit) begin
      mem_q[buf_q[2].addr] <= merge(mem_q[buf_q[2].addr], buf_q[2].b0);
      mem_q[buf_q[2].addr + AB'(1)] <= merge(mem_q[buf_q[2].addr + AB'(1)], buf_q[2].b1);
    end
  end
  function automatic logic [DB-1:0] lookup(input logic [AB-1:0] a);
    logic [DB-1:0] r;
    r = mem_q[a];
    for (int i = 2; i >= 0; i--) begin
      if (bv_q[i] && buf_q[i].addr == a) r = merge(r, buf_q[i].b0);
      if (bv_q[i] && buf_q[i].addr + AB'(1) == a) r = merge(r, buf_q[i].b1);
    end
    return r;
  endfunction

  // ==========================================================
  // read machine and output
  sram_port_pkg::rd_state_t rs_q, rs_d;
  logic [AB-1:0] ra_q, ra_d;
  logic [AB:0] p1_q, p1_d, p2_q, p2_d, src;
  logic [DB-1:0] q_q, q_d;
  logic oe_q, oe_d, cq_q, cq_d;
  logic beat_edge0, beat_edge1;
  always_comb begin
    beat_edge0 = !en_s ? k_rise : (single_clk ? kn_rise : cn_rise);
    beat_edge1 = !en_s ? kn_rise : (single_clk ? k_rise : c_rise);
    // read commands of the last two k cycles, {valid, address}
    p1_d = p1_q;
    p2_d = p2_q;
    if (k_rise) begin
      p1_d = {!rsel_s, a2_q};
      p2_d = p1_q;
    end
    src = !en_s ? p1_q : p2_q;
    rs_d = rs_q;
    ra_d = ra_q;
    q_d = q_q;
    oe_d = oe_q;
    cq_d = cq_q;
    if (beat_edge0) cq_d = 1'b0;
    if (beat_edge1) cq_d = 1'b1;
    unique case (rs_q)
      sram_port_pkg::RD_IDLE, sram_port_pkg::RD_BEAT1: begin
        if (beat_edge0 && src[AB]) begin
          ra_d = src[AB-1:0];
          q_d = lookup(src[AB-1:0]);
          oe_d = 1'b1;
          rs_d = sram_port_pkg::RD_BEAT0;
        end else if (beat_edge0) begin
          oe_d = 1'b0;
          rs_d = sram_port_pkg::RD_IDLE;
        end
      end
      sram_port_pkg::RD_BEAT0: begin
        if (beat_edge1) begin
          q_d = lookup(ra_q + AB'(1));
          rs_d = sram_port_pkg::RD_BEAT1;
        end
      end
      default: rs_d = sram_port_pkg::RD_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      rs_q <= sram_port_pkg::RD_IDLE;
      ra_q <= '0;
      p1_q <= '0;
      p2_q <= '0;
      q_q <= '0;
      oe_q <= 1'b0;
      cq_q <= 1'b1;
    end else begin
      rs_q <= rs_d;
      ra_q <= ra_d;
      p1_q <= p1_d;
      p2_q <= p2_d;
      q_q <= q_d;
      oe_q <= oe_d;
      cq_q <= cq_d;
    end
  end

  always_comb begin
    data_out = q_q;
    data_out_oe = oe_q;
    echo_clock_true = cq_q;
    echo_clock_comp = !cq_q;
    ready = ready_q;
    drive_strength = drv_q;
    fifo_full = !fifo_in_ready;
  end
endmodule

`default_nettype wire

// >>> dv/sram_port_checker.sv
/*
  port checker for sram_port: echo clocks, read timing, calibration, reset.
  assumes the c pair is tied high and reads are only issued once ready.
*/
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// checker
module sram_port_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic k,
  input wire logic k_n,
  input wire logic dll_enable,
  input wire logic read_sel_n,
  input wire logic [sram_port_pkg::DATA_BITS-1:0] data_out,
  input wire logic data_out_oe,
  input wire logic echo_clock_true,
  input wire logic echo_clock_comp,
  input wire logic ready,
  input wire logic [3:0] drive_strength
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  logic [10:0] cal_q;
  logic [10:0] cal_d;
  // cycles since reset, saturating
  always_comb cal_d = reset ? 11'h000 : cal_q + {10'h000, cal_q != 11'h7FF};
  always_ff @(posedge clk) cal_q <= cal_d;
  sequence s_beat0;
    ##[1:5] !echo_clock_true;
  endsequence
  sequence s_beat1;
    ##[1:5] echo_clock_true;
  endsequence
  property p_echo_pair;
    echo_clock_comp == !echo_clock_true;
  endproperty
  a_echo_pair: assert property (p_echo_pair)
    else $error("echo pair not complementary");
  property p_reset_vals;
    @(posedge clk) disable iff (1'b0)
    reset |=> !data_out_oe && !ready && drive_strength == 4'h8 && data_out == '0;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("wrong values in reset");
  property p_cal_final;
    cal_q > 11'h406 |-> drive_strength == 4'hA;
  endproperty
  a_cal_final: assert property (p_cal_final)
    else $error("calibration not settled");
  property p_beat0;
    $rose(k_n) && ready && dll_enable |-> s_beat0;
  endproperty
  a_beat0: assert property (p_beat0)
    else $error("first beat edge missing");
  property p_beat1;
    $rose(k) && ready && dll_enable |-> s_beat1;
  endproperty
  a_beat1: assert property (p_beat1)
    else $error("second beat edge missing");
  property p_bypass;
    $rose(k) && ready && !dll_enable |-> s_beat0;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass beat edge missing");
  property p_read_start;
    $rose(k) && !read_sel_n && ready |-> ##[1:36] data_out_oe;
  endproperty
  a_read_start: assert property (p_read_start)
    else $error("read burst not started");
  property p_oe_hold;
    $rose(data_out_oe) |-> data_out_oe [*8];
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("read burst cut short");
  property p_data_echo;
    $changed(data_out) |-> $changed(echo_clock_true);
  endproperty
  a_data_echo: assert property (p_data_echo)
    else $error("data moved without echo edge");
endmodule

bind sram_port sram_port_checker sram_port_checker_i (.clk, .reset, .k, .k_n, .dll_enable,
  .read_sel_n, .data_out, .data_out_oe, .echo_clock_true, .echo_clock_comp, .ready,
  .drive_strength);
`default_nettype wire

// >>> dv/sram_ctrl_model.sv
/*
  memory controller model: free-running k pair, commands in half-cycle slots.
  assumes clk at 8 ns; drives only on clk falling edges.
*/
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// controller
module sram_ctrl_model (
  input wire logic clk,
  input wire logic [35:0] data_out,
  output logic k,
  output logic k_n,
  output logic read_sel_n,
  output logic write_sel_n,
  output logic [9:0] addr,
  output logic [35:0] data_in,
  output logic [3:0] byte_write_mask_n
);
  int ph = 0;
  initial begin
    k = 1'b0;
    k_n = 1'b1;
    read_sel_n = 1'b1;
    write_sel_n = 1'b1;
    addr = 10'h000;
    data_in = 36'h000000000;
    byte_write_mask_n = 4'hF;
  end
  // k pair at 160 ns, never stopped
  always @(negedge clk) begin
    ph <= (ph == 9) ? 0 : ph + 1;
    if (ph == 9) begin
      k <= ~k;
      k_n <= k;
    end
  end
  task automatic mid(input logic lvl);
    do @(negedge clk); while (ph != 4 || k !== lvl);
  endtask
  // command and beat0 before k rise, addr and beat1 before k_n rise
  task automatic cyc(input logic r, input logic w, input logic [9:0] ra,
      input logic [9:0] wa, input sram_port_pkg::beat_t b0,
      input sram_port_pkg::beat_t b1, output logic [35:0] x0, output logic [35:0] x1);
    mid(1'b0);
    x0 = data_out;
    read_sel_n = r;
    write_sel_n = w;
    addr = ra;
    data_in = w ? ~data_in : b0.data;
    byte_write_mask_n = w ? 4'h0 : b0.byte_write_mask_n;
    mid(1'b1);
    x1 = data_out;
    read_sel_n = 1'b1;
    write_sel_n = 1'b1;
    addr = wa;
    data_in = w ? ~data_in : b1.data;
    byte_write_mask_n = w ? 4'h0 : b1.byte_write_mask_n;
  endtask
endmodule
`default_nettype wire

// >>> dv/sram_port_bench.sv
/*
  bench for sram_port: controller model on the link, c pair tied high.
  assumes the lock count cut to 16 cycles and clock stop detection
  stretched to 16 cycles to suit the slow link clock.
*/
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// bench
module sram_port_bench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic dll_enable = 1'b0;
  logic k, k_n, read_sel_n, write_sel_n, data_out_oe, echo_clock_true, echo_clock_comp;
  logic ready, fifo_full;
  logic [9:0] addr;
  logic [35:0] data_in, data_out, q0, q1;
  logic [3:0] byte_write_mask_n, drive_strength;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  sram_port #(.LOCK_CYCLES(16), .STOP_CYCLES(16)) sram_port_i (.clk, .reset, .k, .k_n,
    .c(1'b1), .c_n(1'b1),
    .dll_enable, .read_sel_n, .write_sel_n, .addr, .data_in, .byte_write_mask_n, .data_out,
    .data_out_oe, .echo_clock_true, .echo_clock_comp, .ready, .drive_strength,
    .fifo_full);
  sram_ctrl_model sram_ctrl_model_i (.clk, .data_out, .k, .k_n, .read_sel_n, .write_sel_n,
    .addr, .data_in, .byte_write_mask_n);
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
      input logic [3:0] m);
    merge = o;
    for (int i = 0; i < 4; i++) begin
      if (m[i] === 1'b0) merge[i*9 +: 9] = n[i*9 +: 9];
    end
  endfunction
  task automatic wr(input logic [9:0] a, input logic [35:0] d0, input logic [35:0] d1,
      input logic [3:0] m0, input logic [3:0] m1);
    sram_ctrl_model_i.cyc(1'b1, 1'b0, a, a, {d0, m0}, {d1, m1}, q0, q1);
  endtask
  task automatic rd(input logic [9:0] a);
    sram_ctrl_model_i.cyc(1'b0, 1'b1, a, a, 40'h0, 40'h0, q0, q1);
  endtask
  task automatic idle_cycle(input logic [9:0] a);
    sram_ctrl_model_i.cyc(1'b1, 1'b1, a, a, 40'h0, 40'h0, q0, q1);
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    cmp({35'h0, ready}, 36'h1);
  endtask
  task automatic t_rw;
    wr(10'h010, 36'h123456789, 36'h0ABCDEF01, 4'h0, 4'h0);
    sram_ctrl_model_i.cyc(1'b0, 1'b0, 10'h010, 10'h020, {36'h111111111, 4'h0},
      {36'h222222222, 4'h0}, q0, q1);
    rd(10'h011);
    idle_cycle(10'h3FF);
    cmp(q0, 36'h123456789);
    cmp(q1, 36'h0ABCDEF01);
    idle_cycle(10'h3FF);
    cmp(q0, 36'h0ABCDEF01);
    $display("t_rw done");
  endtask
  task automatic t_mask;
    wr(10'h020, 36'hFFFFFFFFF, 36'h000000000, 4'hD, 4'h8);
    idle_cycle(10'h020);
    rd(10'h020);
    idle_cycle(10'h3FF);
    idle_cycle(10'h3FF);
    cmp(q0, merge(36'h111111111, 36'hFFFFFFFFF, 4'hD));
    cmp(q1, merge(36'h222222222, 36'h000000000, 4'h8));
    $display("t_mask done");
  endtask
  task automatic t_commit;
    for (int i = 1; i <= 4; i++) begin
      wr(10'h100 + 10'(i * 4), 36'(i), 36'h0, 4'h0, 4'h0);
    end
    rd(10'h110);
    rd(10'h010);
    cmp({35'h0, fifo_full}, 36'h0);
    idle_cycle(10'h3FF);
    cmp(q0, 36'h4);
    cmp(q1, 36'h0);
    idle_cycle(10'h3FF);
    cmp(q0, 36'h123456789);
    cmp(q1, 36'h0ABCDEF01);
    $display("t_commit done");
  endtask
  task automatic t_bypass;
    dll_enable = 1'b0;
    repeat (40) @(negedge clk);
    rd(10'h010);
    idle_cycle(10'h3FF);
    cmp(q1, 36'h123456789);
    idle_cycle(10'h3FF);
    cmp(q0, 36'h0ABCDEF01);
    dll_enable = 1'b1;
    repeat (8) @(negedge clk);
    wait_ready;
    rd(10'h110);
    idle_cycle(10'h3FF);
    idle_cycle(10'h3FF);
    cmp(q0, 36'h4);
    $display("t_bypass done");
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    dll_enable = 1'b1;
    wait_ready;
    t_rw();
    t_mask();
    t_commit();
    t_bypass();
    end_of_test();
  end
endmodule
`default_nettype wire
